// File: hdl/pcr_control_regs.sv
// control logic: reset generation, core code, straps, alert and serial register slave
`timescale 1ns/10ps
module pcr_control_regs
    import pcr_pkg::*;
#(
    parameter int DEBOUNCE_CYC_P    = pcr_pkg::DEBOUNCE_CYC,
    parameter int RESET_DELAY_CYC_P = pcr_pkg::RESET_DELAY_CYC
) (
    input  wire logic                  sys_clk,          // 40 MHz clock
    input  wire logic                  arst_n,           // async reset, active low
    input  wire logic                  backup_rail_good, // backup rail comparator
    input  wire logic                  undervoltage_lockout_active,      // undervoltage lockout
    input  wire logic                  warm_reset_in_n,  // warm reset pin, low active
    input  wire pcr_pkg::pcr_straps_t  straps,           // strap pins
    input  wire pcr_pkg::pcr_en_pins_t en_pins,          // enable pins
    input  wire pcr_pkg::pcr_cmp_t     cmp,              // supply comparators
    input  wire logic                  dvc_active,       // voltage change in progress
    input  wire logic                  scl_i,            // serial clock in
    input  wire logic                  sda_i,            // serial data in
    output logic                       sda_o,            // serial data out level
    output logic                       sda_oe,           // serial data pull low
    output logic                       system_reset_o,   // reset pin level
    output logic                       system_reset_oe,  // reset pin pull low
    output logic                       supply_alert_o,   // alert pin level
    output logic                       supply_alert_oe,  // alert pin pull low
    output logic [4:0]                 supply_on,        // sys,mem,core,ldo_b,ldo_a
    output logic [4:0]                 core_code,        // core rail voltage code
    output logic [11:0]                ldo_a_mv,         // LDO A voltage, mV
    output logic [11:0]                ldo_b_mv          // LDO B voltage, mV
);
    import pcr_pkg::*;

    localparam int RW = $clog2(RESET_DELAY_CYC_P + 1);

    generate
        if (DEBOUNCE_CYC_P < 2 || RESET_DELAY_CYC_P < 1)
        begin : g_bad_param
            $error("pcr_control_regs: delay parameters too small");
        end
    endgenerate

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
    } pcr_i2c_st_t;

    // synchronised inputs
    logic         bgood_s;
    logic         undervoltage_lockout_s;
    logic         warm_n_s;
    pcr_straps_t  straps_s;
    pcr_en_pins_t pins_s;
    pcr_cmp_t     cmp_s;
    logic         dvc_s;
    logic         scl_s;
    logic         sda_s;

    // warm reset and serial lines reset high, so no false edge or warm reset follows reset
    pcr_sync #(.W(20), .RST(20'h20003)) u_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .d       ({backup_rail_good, undervoltage_lockout_active, warm_reset_in_n, straps, en_pins,
                   cmp, dvc_active, scl_i, sda_i}),
        .q       ({bgood_s, undervoltage_lockout_s, warm_n_s, straps_s, pins_s, cmp_s, dvc_s,
                   scl_s, sda_s})
    );

    logic warm_n_db;

    // [R2] warm reset filter
    pcr_debounce #(.CYC(DEBOUNCE_CYC_P), .INIT(1'b1)) u_warm_db (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .raw      (warm_n_s),
        .stable_q (warm_n_db)
    );

    logic          warm_act;
    logic          rst_hold;
    logic [RW-1:0] rst_cnt_q;
    logic          reset_oe_q;
    logic          od_low_q;

    assign warm_act = !warm_n_db;
    // [R1] backup rail, lockout and warm reset hold reset
    assign rst_hold = !bgood_s || undervoltage_lockout_s || warm_act;

    // delay counter restarts on every hold
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_cnt_q <= '0;
        else if (rst_hold)
            rst_cnt_q <= '0;
        else if (rst_cnt_q != RW'(RESET_DELAY_CYC_P))
            rst_cnt_q <= rst_cnt_q + 1'b1;
    end

    // [R1] reset stays low until the delay expires
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            reset_oe_q <= 1'b1;
        else
            reset_oe_q <= rst_hold || (rst_cnt_q != RW'(RESET_DELAY_CYC_P));
    end

    // open-drain pins only ever pull low
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            od_low_q <= 1'b0;
        else
            od_low_q <= 1'b0;
    end

    // straps are caught after lockout or reset release, never at the async edge
    logic [1:0]  strap_wait_q;
    logic [1:0]  ldo_sel_q;
    logic [11:0] ldo_a_q;
    logic [11:0] ldo_b_q;

    // [R6] latch LDO straps at power-up
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_wait_q <= 2'b11;
            ldo_sel_q    <= 2'b00;
        end
        // keep sampling until the synchroniser shows the real pin level
        else if (undervoltage_lockout_s || strap_wait_q != 2'b00)
        begin
            strap_wait_q <= undervoltage_lockout_s ? 2'b11 : strap_wait_q - 2'b01;
            ldo_sel_q    <= {straps_s.ldo_b, straps_s.ldo_a};
        end
    end

    // [R6] table lookup of initial LDO voltages
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ldo_a_q <= '0;
            ldo_b_q <= '0;
        end
        else
        begin
            ldo_a_q <= LDO_A_MV[ldo_sel_q];
            ldo_b_q <= LDO_B_MV[ldo_sel_q];
        end
    end

    // register file and serial slave signals
    logic [7:0]  mask_q;
    logic [7:0]  enable_q;
    logic [7:0]  enable_d;
    logic [7:0]  fault_q;
    logic [7:0]  fault_d;
    logic [7:0]  block_q;
    logic [4:0]  on_q;
    logic [4:0]  on_d;
    logic [4:0]  core_q;
    logic [4:0]  core_def;
    logic        core_rst;
    logic        alert_q;
    pcr_i2c_st_t st_q;
    pcr_i2c_st_t ack_next_q;
    logic [3:0]  cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic [7:0]  ptr_q;
    logic        sda_oe_q;
    logic        scl_p_q;
    logic        sda_p_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        wr_fire;
    logic        rd_fire;
    logic [7:0]  rd_data;

    // single place for the address decode of reads
    function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] flt,
                                            input logic [7:0] msk, input logic [7:0] en);
        case (a)
            // [R17] fixed code, nothing writes it
            ADR_REVISION: read_reg = REVISION_ID;
            ADR_FAULT:    read_reg = flt;
            ADR_MASK:     read_reg = msk;
            ADR_ENABLE:   read_reg = en;
            // [R12] unmapped reads
            default:      read_reg = UNMAPPED_RD;
        endcase
    endfunction : read_reg

    // [R20] supply on only when bit and pin both high
    assign on_d = enable_q[5:1] & {pins_s.sys_buck, pins_s.mem_buck, pins_s.core_buck,
                                   pins_s.ldo, pins_s.ldo};

    // [R18] below-target bits read zero for disabled supplies
    assign fault_d = {cmp_s.power_fail, cmp_s.low_battery,
                      cmp_s.sys_low & on_q[4], cmp_s.mem_low & on_q[3],
                      // [R19] core bit cleared during voltage change
                      cmp_s.core_low & on_q[2] & !dvc_s,
                      cmp_s.ldo_b_low & on_q[1], cmp_s.ldo_a_low & on_q[0], 1'b0};

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fault_q <= '0;
            on_q    <= '0;
        end
        else
        begin
            fault_q <= fault_d;
            on_q    <= on_d;
        end
    end

    // serial line edges, taken from synchronised copies only
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // [R13] sampling at 40 MHz leaves ample margin at 400 kHz
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start_c  = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_c   = scl_s && scl_p_q && !sda_p_q && sda_s;
    assign wr_fire  = scl_fall && st_q == ST_WDATA && cnt_q == 4'h8;
    assign rd_fire  = scl_fall && st_q == ST_ACK && ack_next_q == ST_RDATA;
    assign rd_data  = read_reg(ptr_q, fault_q, mask_q, enable_q);

    // serial slave state machine; data only changes while the clock is low
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q       <= ST_IDLE;
            ack_next_q <= ST_IDLE;
            cnt_q      <= '0;
            shift_q    <= '0;
            tx_q       <= '0;
            sda_oe_q   <= 1'b0;
        end
        else if (start_c)
        begin
            st_q     <= ST_ADDR;
            cnt_q    <= '0;
            sda_oe_q <= 1'b0;
        end
        else if (stop_c)
        begin
            st_q     <= ST_IDLE;
            sda_oe_q <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (st_q)
                ST_ADDR, ST_REG, ST_WDATA, ST_RDATA:
                begin
                    shift_q <= {shift_q[6:0], sda_s};
                    cnt_q   <= cnt_q + 1'b1;
                end
                // [R16] no acknowledge ends the read; line stays released
                ST_MACK:
                begin
                    st_q       <= sda_s ? ST_IDLE : ST_ACK;
                    ack_next_q <= ST_RDATA;
                end
                default:
                begin
                    st_q <= st_q;
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (st_q)
                ST_ADDR:
                begin
                    if (cnt_q == 4'h8)
                    begin
                        // [R11] only our address is answered
                        if (shift_q[7:1] == I2C_ADDR)
                        begin
                            st_q       <= ST_ACK;
                            ack_next_q <= shift_q[0] ? ST_RDATA : ST_REG;
                            sda_oe_q   <= 1'b1;
                        end
                        else
                        begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_REG, ST_WDATA:
                begin
                    if (cnt_q == 4'h8)
                    begin
                        // [R14] acknowledge held low across the ninth clock high
                        st_q       <= ST_ACK;
                        ack_next_q <= ST_WDATA;
                        sda_oe_q   <= 1'b1;
                    end
                end
                ST_ACK:
                begin
                    cnt_q <= '0;
                    st_q  <= ack_next_q;
                    if (ack_next_q == ST_RDATA)
                    begin
                        tx_q     <= rd_data;
                        sda_oe_q <= !rd_data[7];
                    end
                    else
                    begin
                        sda_oe_q <= 1'b0;
                    end
                end
                ST_RDATA:
                begin
                    if (cnt_q == 4'h8)
                    begin
                        st_q     <= ST_MACK;
                        sda_oe_q <= 1'b0;
                    end
                    else
                    begin
                        tx_q     <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= !tx_q[6];
                    end
                end
                default:
                begin
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // register pointer: set by the first data byte, then advances per byte
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ptr_q <= '0;
        else if (scl_fall && st_q == ST_REG && cnt_q == 4'h8)
            ptr_q <= shift_q;
        else if (wr_fire || rd_fire)
            ptr_q <= ptr_q + 1'b1;
    end

    // [R10] mask loads C0h on lockout
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            mask_q <= MASK_RST;
        else if (undervoltage_lockout_s)
            mask_q <= MASK_RST;
        else if (wr_fire && ptr_q == ADR_MASK)
            mask_q <= shift_q & MASK_RW_BITS;
    end

    // [R22] pins low force their bits to one, winning over a write
    always_comb
    begin
        enable_d = enable_q;
        if (wr_fire && ptr_q == ADR_ENABLE)
            enable_d = (shift_q & ENABLE_RW_BITS) | ~ENABLE_RW_BITS;
        enable_d = enable_d | {2'b00, !pins_s.sys_buck, !pins_s.mem_buck,
                               !pins_s.core_buck, !pins_s.ldo, !pins_s.ldo, 1'b0};
    end

    // [R21] lockout loads FFh
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            enable_q <= ENABLE_RST;
        else if (undervoltage_lockout_s)
            enable_q <= ENABLE_RST;
        else
            enable_q <= enable_d;
    end

    // [R8] bits active at a status read stay blocked until they clear
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            block_q <= '0;
        else if (undervoltage_lockout_s)
            block_q <= '0;
        else if (rd_fire && ptr_q == ADR_FAULT)
            block_q <= fault_q;
        else
            block_q <= block_q & fault_q;
    end

    // [R7] [R9] [R23] alert pulls low on any unmasked, unblocked fault
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            alert_q <= 1'b0;
        else
            alert_q <= |(fault_q & ~mask_q & ~block_q);
    end

    // [R3] [R4] defaults; warm reset touches only this code
    assign core_def = straps_s.core ? CORE_DEF_HI : CORE_DEF_LO;
    assign core_rst = rst_hold || reset_oe_q || (!on_d[4] && !on_d[2]);

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            core_q <= CORE_DEF_LO;
        else if (core_rst)
            core_q <= core_def;
        // [R5] system rail off forces 1xxx0
        else if (!on_d[4])
            core_q <= {1'b1, core_q[3:1], 1'b0};
    end

    assign sda_o           = od_low_q;
    assign sda_oe          = sda_oe_q;
    assign system_reset_o  = od_low_q;
    assign system_reset_oe = reset_oe_q;
    assign supply_alert_o  = od_low_q;
    assign supply_alert_oe = alert_q;
    assign supply_on       = on_q;
    assign core_code       = core_q;
    assign ldo_a_mv        = ldo_a_q;
    assign ldo_b_mv        = ldo_b_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_warm_seen;
        $fell(warm_n_db) ##1 1'b1;
    endsequence

    sequence s_reset_low2;
        system_reset_oe [*2];
    endsequence

    AST_RESET_ON_BACKUP: assert property (!bgood_s |=> system_reset_oe) // [R1]
        else $error("reset not held while backup rail bad");
    AST_WARM_TRIGGERS: assert property (s_warm_seen |-> s_reset_low2) // [R2]
        else $error("warm reset did not hold system reset");
    AST_CORE_DEFAULT: assert property (undervoltage_lockout_s |=> core_code == $past(core_def)) // [R4]
        else $error("core code not defaulted on lockout");
    AST_CORE_1XXX0: assert property (!on_d[4] |=> core_code[4] && !core_code[0]) // [R5]
        else $error("core code not forced to 1xxx0");
    AST_MASK_ALL: assert property (mask_q == 8'hFE ##1 mask_q == 8'hFE |=> !supply_alert_oe) // [R9]
        else $error("masked fault reached alert");
    AST_UNDERVOLTAGE_LOCKOUT_MASK: assert property (undervoltage_lockout_s |=> mask_q == MASK_RST && enable_q == ENABLE_RST) // [R10]
        else $error("lockout defaults not loaded");
    AST_FOREIGN_ADDR: assert property (scl_fall && st_q == ST_ADDR && cnt_q == 4'h8 &&
        shift_q[7:1] != I2C_ADDR |=> !sda_oe) // [R11]
        else $error("acknowledged a foreign address");
    AST_ACK_HELD: assert property (st_q == ST_ACK && sda_oe_q && scl_s |=> sda_oe) // [R14]
        else $error("acknowledge released during clock high");
    AST_DVC_CLEAR: assert property (dvc_s |=> !fault_q[BIT_CORE]) // [R19]
        else $error("core fault bit set during voltage change");
    AST_SUPPLY_AND: assert property (!pins_s.sys_buck |=> !supply_on[4]) // [R20]
        else $error("supply on with its pin low");
    AST_PIN_HOLDS: assert property (!pins_s.core_buck && !undervoltage_lockout_s |=> enable_q[3]) // [R22]
        else $error("enable bit not held at one");
endmodule : pcr_control_regs

// File: hdl/pcr_debounce.sv
// level debouncer: output follows input after it stays steady for CYC cycles
`timescale 1ns/10ps
module pcr_debounce #(
    parameter int   CYC = 2,
    parameter logic INIT = 1'b1
) (
    input  wire logic sys_clk,  // system clock
    input  wire logic arst_n,   // async reset, active low
    input  wire logic raw,      // synchronised noisy level
    output logic      stable_q  // filtered level
);
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_q;

    // any bounce restarts the count, so short glitches never pass
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q    <= '0;
            stable_q <= INIT;
        end
        else if (raw == stable_q)
        begin
            cnt_q <= '0;
        end
        else if (cnt_q == CW'(CYC - 1))
        begin
            cnt_q    <= '0;
            stable_q <= raw;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : pcr_debounce

// File: hdl/pcr_sync.sv
// two-flop synchroniser for a bundle of independent levels
`timescale 1ns/10ps
module pcr_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0  // level held during reset
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         arst_n,  // async reset, active low
    input  wire logic [W-1:0] d,       // asynchronous levels
    output logic      [W-1:0] q        // synchronised levels
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= RST;
            q      <= RST;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : pcr_sync

// File: shared/pcr_pkg.sv
// shared constants, layouts and carriers for the power-management control registers
// Functional notes
// [R1] Hold system reset low while backup rail is bad, then for a set delay.
// [R2] Debounce warm reset input about 30 ms; qualified assertion also triggers system reset.
// [R3] Warm reset restores only the core rail code to its strap default.
// [R4] Core code defaults on backup bad, lockout, system reset, or both bucks off.
// [R5] System rail off forces core code to 1xxx0, middle bits kept.
// [R6] LDO strap pins latched at power-up pick initial LDO voltages from table.
// [R7] Alert output reports supplies ok only when every enabled supply regulates.
// [R8] Reading fault status blocks the then-active bits from the alert output.
// [R9] A set mask bit hides the matching fault bit from the alert output.
// [R10] Lockout loads mask with C0h: power fail and low battery masked.
// [R11] Answer only the seven-bit serial address 1001000.
// [R12] Reading an unmapped register address returns FFh.
// [R13] Serial link runs standard and fast mode, master clock up to 400 kHz.
// [R14] Acknowledge each byte with data held low through acknowledge clock high.
// [R15] Master supplies a ninth clock pulse per byte for the acknowledge.
// [R16] Master ends reads with no acknowledge; device then releases the data line.
// [R17] Register 00h returns a fixed revision code; writes to it are ignored.
// [R18] Supply fault bit is one when output below target, zero if off.
// [R19] Core rail fault bit reads zero throughout a dynamic voltage change.
// [R20] Each supply enable bit is ANDed with its enable pin.
// [R21] Lockout loads the supply enable register with FFh.
// [R22] While an enable pin is low its enable bits are held at one.
// [R23] Alert pulled low when any fault is unmasked and unblocked, else released.
package pcr_pkg;
    localparam logic [6:0]  I2C_ADDR       = 7'h48;
    localparam int          I2C_MAX_KHZ    = 400;
    localparam logic [7:0]  ADR_REVISION   = 8'h00;
    localparam logic [7:0]  ADR_FAULT      = 8'h01;
    localparam logic [7:0]  ADR_MASK       = 8'h02;
    localparam logic [7:0]  ADR_ENABLE     = 8'h03;
    // arbitrary neutral value, not a real part code
    localparam logic [7:0]  REVISION_ID    = 8'h5A;
    localparam logic [7:0]  MASK_RST       = 8'hC0;
    localparam logic [7:0]  MASK_RW_BITS   = 8'hFE;
    localparam logic [7:0]  ENABLE_RST     = 8'hFF;
    localparam logic [7:0]  ENABLE_RW_BITS = 8'h3E;
    localparam logic [7:0]  UNMAPPED_RD    = 8'hFF;
    localparam int          BIT_CORE       = 3;
    localparam logic [4:0]  CORE_DEF_LO    = 5'h14;
    localparam logic [4:0]  CORE_DEF_HI    = 5'h1E;
    localparam logic [11:0] LDO_A_MV [4]   = '{12'd1100, 12'd1500, 12'd2600, 12'd3150};
    localparam logic [11:0] LDO_B_MV [4]   = '{12'd1300, 12'd1300, 12'd2800, 12'd3300};
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          DEBOUNCE_MS    = 30;
    localparam int          RESET_DELAY_MS = 100;
    localparam int          DEBOUNCE_CYC   = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int          RESET_DELAY_CYC = CLK_HZ / 1000 * RESET_DELAY_MS;

    // enable pins of the converters and LDOs
    typedef struct packed {
        logic sys_buck;
        logic mem_buck;
        logic core_buck;
        logic ldo;
    } pcr_en_pins_t;

    // strap pins
    typedef struct packed {
        logic core;
        logic ldo_b;
        logic ldo_a;
    } pcr_straps_t;

    // comparator outputs, one means low or failing, order matches status bits 7..1
    typedef struct packed {
        logic power_fail;
        logic low_battery;
        logic sys_low;
        logic mem_low;
        logic core_low;
        logic ldo_b_low;
        logic ldo_a_low;
    } pcr_cmp_t;
endpackage : pcr_pkg

// File: verif/pcr_control_regs_tb.sv
// self-checking bench for the control block over its serial link
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module pcr_control_regs_tb;
    import pcr_pkg::*;
    logic sys_clk = 1'b0, arst_n = 1'b0, bk = 1'b1, uv = 1'b0, wr_n = 1'b1, sda_oe, h_oe, scl;
    logic rst_oe, al_oe, sda;
    pcr_straps_t st = 3'b001;
    pcr_en_pins_t en = 4'hF;
    pcr_cmp_t cm = '0;
    logic [4:0] son, cc;
    logic [11:0] la, lb;
    logic [7:0] v;
    logic a, dv = 1'b0;
    int num_errors = 0, n_checks = 0;
    logic [7:0] adr [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
    logic [7:0] exv [5] = '{REVISION_ID, 8'h00, 8'hC0, 8'hFF, 8'hFF};
    always #12.5 sys_clk = !sys_clk;
    // open drain data line with pull-up
    assign sda = (h_oe | sda_oe) ? 1'b0 : 1'b1;
    pcr_control_regs #(.DEBOUNCE_CYC_P(8), .RESET_DELAY_CYC_P(20)) dut (.sys_clk(sys_clk),
        .arst_n(arst_n), .backup_rail_good(bk), .undervoltage_lockout_active(uv), .warm_reset_in_n(wr_n),
        .straps(st), .en_pins(en), .cmp(cm), .dvc_active(dv), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe(sda_oe), .system_reset_o(), .system_reset_oe(rst_oe),
        .supply_alert_o(), .supply_alert_oe(al_oe), .supply_on(son), .core_code(cc),
        .ldo_a_mv(la), .ldo_b_mv(lb));
    pcr_i2c_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        logic a;
        host.start();
        host.xb({I2C_ADDR, 1'b0}, 1'b1, d, a);
        host.xb(ad, 1'b1, d, a);
        host.start();
        host.xb({I2C_ADDR, 1'b1}, 1'b1, d, a);
        `CHK("addr ack", 1'b0, a)
        host.xb(8'hFF, 1'b1, d, a);
        `CHK("release", 1'b1, sda)
        host.stop();
    endtask : rd
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        logic [7:0] r;
        logic a;
        host.start();
        host.xb({I2C_ADDR, 1'b0}, 1'b1, r, a);
        host.xb(ad, 1'b1, r, a);
        host.xb(d, 1'b1, r, a);
        `CHK("data ack", 1'b0, a)
        host.stop();
    endtask : wr
    // hang guard, the run needs well under this
    initial
    begin
        #2ms;
        num_errors++;
        test_done();
    end
    initial
    begin
        host.w(8);
        arst_n = 1'b1;
        host.w(40);
        `CHK("rst", 1'b0, rst_oe)
        `CHK("ldo_a", 12'd1500, la)
        `CHK("ldo_b", 12'd1300, lb)
        `CHK("core", 5'h14, cc)
        for (int i = 0; i < 5; i++)
        begin
            rd(adr[i], v);
            `CHK("reg", exv[i], v)
        end
        wr(8'h00, 8'h00);
        rd(8'h00, v);
        `CHK("rev", REVISION_ID, v)
        host.start();
        host.xb(8'h92, 1'b1, v, a);
        `CHK("foreign nack", 1'b1, a)
        host.stop();
        wr(8'h02, 8'h00);
        cm.sys_low = 1'b1;
        host.w(10);
        `CHK("alert", 1'b1, al_oe)
        rd(8'h01, v);
        `CHK("fault", 8'h20, v)
        host.w(4);
        `CHK("blocked", 1'b0, al_oe)
        cm = '0;
        wr(8'h02, 8'hFE);
        cm = '1;
        dv = 1'b1;
        host.w(10);
        `CHK("masked", 1'b0, al_oe)
        rd(8'h01, v);
        `CHK("all faults", 8'hF6, v)
        cm = '0;
        dv = 1'b0;
        wr(8'h03, 8'h00);
        `CHK("off", 5'h00, son)
        en.ldo = 1'b0;
        host.w(10);
        en.ldo = 1'b1;
        host.w(10);
        `CHK("ldo on", 5'h03, son)
        wr_n = 1'b0;
        host.w(30);
        `CHK("warm", 1'b1, rst_oe)
        `CHK("core def", 5'h14, cc)
        wr_n = 1'b1;
        host.w(60);
        rd(8'h03, v);
        `CHK("kept", 8'hC7, v)
        st = 3'b110;
        uv = 1'b1;
        host.w(6);
        uv = 1'b0;
        host.w(8);
        `CHK("ldo_a relatch", 12'd2600, la)
        `CHK("ldo_b relatch", 12'd2800, lb)
        `CHK("core hi", 5'h1E, cc)
        rd(8'h03, v);
        `CHK("enable lockout", 8'hFF, v)
        bk = 1'b0;
        host.w(6);
        `CHK("backup", 1'b1, rst_oe)
        test_done();
    end
endmodule : pcr_control_regs_tb

// File: verif/pcr_i2c_host.sv
// serial bus master model for the control block
`timescale 1ns/10ps
module pcr_i2c_host (
    input  wire logic sys_clk, // bench clock
    input  wire logic sda,     // resolved data line
    output logic      scl,     // serial clock
    output logic      sda_oe   // pull data low
);
    // clock stands high while no frame runs
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // four falling edges give half a 200 ns link period
    task automatic w(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : w
    // start, also used as repeated start
    task automatic start();
        sda_oe = 1'b0;
        w(4);
        scl = 1'b1;
        w(4);
        sda_oe = 1'b1;
        w(4);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        sda_oe = 1'b1;
        w(4);
        scl = 1'b1;
        w(4);
        sda_oe = 1'b0;
        w(4);
    endtask : stop
    // eight bits plus the ninth clock; ackb high releases data
    task automatic xb(input logic [7:0] d, input logic ackb, output logic [7:0] r,
                      output logic a);
        logic [8:0] v;
        logic [8:0] q;
        v = {d, ackb};
        for (int i = 8; i >= 0; i--)
        begin
            sda_oe = !v[i];
            w(4);
            scl = 1'b1;
            w(2);
            q[i] = sda;
            w(2);
            scl = 1'b0;
        end
        {r, a} = q;
    endtask : xb
endmodule : pcr_i2c_host
